// file: verilog/in_bank_pkg.sv
// package: offsets, field positions and types of the input register bank
package in_bank_pkg;
    localparam int NUM_CH = 6;
    localparam int NUM_CH_SMALL = 4;
    localparam logic [15:0] OFF_STATUS = 16'h0000;
    localparam logic [15:0] OFF_RANGE_CH0 = 16'h0001;
    localparam logic [15:0] OFF_RANGE_CH5 = 16'h0006;
    localparam logic [15:0] OFF_COUNT_CH0 = 16'h0007;
    localparam logic [15:0] OFF_COUNT_CH1 = 16'h8000;
    localparam logic [15:0] OFF_COUNT_CH2 = 16'h0009;
    localparam logic [15:0] OFF_COUNT_CH3 = 16'h000a;
    localparam logic [15:0] OFF_COUNT_CH4 = 16'h000b;
    localparam logic [15:0] OFF_COUNT_CH5 = 16'h000c;
    localparam int WINK_BIT = 14;
    localparam int DEFAULT_BIT = 13;
    localparam int TIMEOUT_LSB = 0;
    localparam int RANGE_W = 2;
    localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FUNC_READ_INPUT = 8'h04;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    // 43000 decimal
    localparam logic [15:0] MIRROR_REF_BASE = 16'ha7f8;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] CODE_RESET = 8'h00;

    typedef enum logic [1:0] {
        CUR_0_20MA = 2'h0,
        CUR_4_20MA = 2'h1,
        CUR_0_1MA = 2'h2,
        CUR_RESERVED = 2'h3
    } current_range_e;
    typedef enum logic [1:0] {
        VOLT_0_10V = 2'h0,
        VOLT_0_5V = 2'h1,
        VOLT_0_1V = 2'h2,
        VOLT_RESERVED = 2'h3
    } voltage_range_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOOKUP = 2'h1,
        ST_ANSWER = 2'h3
    } bank_state_e;

    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
    } read_req_s;
    typedef struct packed {
        logic exception;
        logic [7:0] code;
        logic [15:0] data;
    } read_rsp_s;
    typedef struct packed {
        logic hit;
        logic is_status;
        logic is_count;
        logic [2:0] ch;
    } reg_sel_s;

    function automatic reg_sel_s decode_offset(input logic [15:0] off);
        reg_sel_s s;
        s = '0;
        s.hit = 1'b1;
        if (off == OFF_STATUS) begin
            s.is_status = 1'b1;
        end else if (off >= OFF_RANGE_CH0 && off <= OFF_RANGE_CH5) begin
            s.ch = 3'(off - OFF_RANGE_CH0);
        end else begin
            s.is_count = 1'b1;
            case (off)
                OFF_COUNT_CH0: s.ch = 3'h0;
                OFF_COUNT_CH1: s.ch = 3'h1;
                OFF_COUNT_CH2: s.ch = 3'h2;
                OFF_COUNT_CH3: s.ch = 3'h3;
                OFF_COUNT_CH4: s.ch = 3'h4;
                OFF_COUNT_CH5: s.ch = 3'h5;
                default: s.hit = 1'b0;
            endcase
        end
        return s;
    endfunction
endpackage

// file: verilog/status_word_build.sv
// module status word assembled from the live module flags
module status_word_build (
    // module flags
    input wire logic wink_active,
    input wire logic default_mode,
    input wire logic [in_bank_pkg::NUM_CH-1:0] wd_timeout,
    // assembled word
    output logic [15:0] word
);
    // unused bits stay at the zero reset pattern
    always_comb begin
        word = in_bank_pkg::WORD_RESET;
        word[in_bank_pkg::WINK_BIT] = wink_active;
        word[in_bank_pkg::DEFAULT_BIT] = default_mode;
        word[in_bank_pkg::TIMEOUT_LSB +: in_bank_pkg::NUM_CH] = wd_timeout;
    end
endmodule

// file: verilog/chan_word_select.sv
// range or converter count word of one channel
module chan_word_select (
    // selection
    input wire in_bank_pkg::reg_sel_s sel,
    input wire logic six_channel,
    // channel state
    input wire logic [in_bank_pkg::NUM_CH-1:0][in_bank_pkg::RANGE_W-1:0] ch_range,
    input wire logic [in_bank_pkg::NUM_CH-1:0][15:0] ch_count,
    // selected word
    output logic [15:0] word
);
    logic absent;

    // channels 4 and 5 are not fitted on small variants
    assign absent = !six_channel && (sel.ch >= 3'(in_bank_pkg::NUM_CH_SMALL));

    always_comb begin
        word = in_bank_pkg::WORD_RESET;
        if (absent || sel.ch >= 3'(in_bank_pkg::NUM_CH)) begin
            word = in_bank_pkg::WORD_RESET;
        end else if (sel.is_count) begin
            word = ch_count[sel.ch];
        end else begin
            // code passed through unchanged for either output family
            word[in_bank_pkg::RANGE_W-1:0] = ch_range[sel.ch];
        end
    end
endmodule

// file: verilog/input_reg_bank.sv
// read-only input register bank answering register read requests
module input_reg_bank (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // read request
    input wire logic req_valid,
    input wire in_bank_pkg::read_req_s req,
    output logic req_ready,
    // read answer
    output logic rsp_valid,
    output in_bank_pkg::read_rsp_s rsp,
    // module state
    input wire logic wink_active,
    input wire logic default_mode,
    input wire logic [in_bank_pkg::NUM_CH-1:0] wd_timeout,
    input wire logic six_channel,
    input wire logic [in_bank_pkg::NUM_CH-1:0][in_bank_pkg::RANGE_W-1:0] ch_range,
    input wire logic [in_bank_pkg::NUM_CH-1:0][15:0] ch_count
);
    in_bank_pkg::bank_state_e state_r;
    in_bank_pkg::bank_state_e state_nxt;
    in_bank_pkg::read_req_s req_r;
    in_bank_pkg::read_req_s req_nxt;
    in_bank_pkg::read_rsp_s rsp_r;
    in_bank_pkg::read_rsp_s rsp_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic req_ready_r;
    logic req_ready_nxt;
    logic [15:0] eff_off;
    logic func_ok;
    logic addr_ok;
    logic is_mirror;
    in_bank_pkg::reg_sel_s sel;
    logic [15:0] status_word;
    logic [15:0] chan_word;

    status_word_build u_status (
        .wink_active(wink_active),
        .default_mode(default_mode),
        .wd_timeout(wd_timeout),
        .word(status_word)
    );

    chan_word_select u_chan (
        .sel(sel),
        .six_channel(six_channel),
        .ch_range(ch_range),
        .ch_count(ch_count),
        .word(chan_word)
    );

    // request is held in req_r, so the decode is stable through the answer
    always_comb begin
        func_ok = 1'b0;
        is_mirror = 1'b0;
        eff_off = req_r.addr;
        if (req_r.func == in_bank_pkg::FUNC_READ_INPUT) begin
            func_ok = 1'b1;
        end else if (req_r.func == in_bank_pkg::FUNC_READ_HOLDING) begin
            // reference 43001 lands on input offset 0
            func_ok = 1'b1;
            is_mirror = 1'b1;
            eff_off = 16'(req_r.addr - in_bank_pkg::MIRROR_REF_BASE - 16'h0001);
        end
        sel = in_bank_pkg::decode_offset(eff_off);
        // holding space below the mirror window is not served here
        addr_ok = sel.hit && !(is_mirror && req_r.addr <= in_bank_pkg::MIRROR_REF_BASE);
    end

    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        rsp_nxt = rsp_r;
        rsp_valid_nxt = 1'b0;
        case (state_r)
            in_bank_pkg::ST_IDLE: begin
                if (req_valid && req_ready_r) begin
                    req_nxt = req;
                    state_nxt = in_bank_pkg::ST_LOOKUP;
                end
            end
            in_bank_pkg::ST_LOOKUP: begin
                rsp_valid_nxt = 1'b1;
                state_nxt = in_bank_pkg::ST_ANSWER;
                if (!func_ok) begin
                    rsp_nxt.exception = 1'b1;
                    rsp_nxt.code = in_bank_pkg::EXC_ILLEGAL_FUNC;
                    rsp_nxt.data = in_bank_pkg::WORD_RESET;
                end else if (!addr_ok) begin
                    rsp_nxt.exception = 1'b1;
                    rsp_nxt.code = in_bank_pkg::EXC_ILLEGAL_ADDR;
                    rsp_nxt.data = in_bank_pkg::WORD_RESET;
                end else begin
                    rsp_nxt.exception = 1'b0;
                    rsp_nxt.code = req_r.func;
                    // mirror and direct reads share one word, same format
                    rsp_nxt.data = sel.is_status ? status_word : chan_word;
                end
            end
            in_bank_pkg::ST_ANSWER: begin
                state_nxt = in_bank_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = in_bank_pkg::ST_IDLE;
            end
        endcase
        // ready only while idle: one request in flight keeps the answer simple
        req_ready_nxt = (state_nxt == in_bank_pkg::ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= in_bank_pkg::ST_IDLE;
            req_r <= '0;
            rsp_r <= '0;
            rsp_valid_r <= 1'b0;
            req_ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            rsp_r <= rsp_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            req_ready_r <= req_ready_nxt;
        end
    end

    assign req_ready = req_ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;

    // checks
    logic ans_ok;
    logic ans_status;
    logic ans_range;
    logic ans_count;
    logic ans_absent;

    assign ans_ok = rsp_valid_r && !rsp_r.exception;
    assign ans_status = ans_ok && sel.is_status;
    assign ans_range = ans_ok && !sel.is_status && !sel.is_count;
    assign ans_count = ans_ok && sel.is_count;
    assign ans_absent = ans_ok && !sel.is_status && (sel.ch >= 3'(in_bank_pkg::NUM_CH_SMALL));

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    chk_wink_flag: assert property (
        ans_status |-> rsp_r.data[in_bank_pkg::WINK_BIT] == $past(wink_active))
        else $error("status wink bit does not follow blink mode");
    chk_default_flag: assert property (
        ans_status |-> rsp_r.data[in_bank_pkg::DEFAULT_BIT] == $past(default_mode))
        else $error("status default bit does not follow default mode");
    chk_timeout_bits: assert property (
        ans_status |-> rsp_r.data[5:0] == $past(wd_timeout))
        else $error("status timeout bits differ from channel timeouts");
    chk_status_unused: assert property (
        ans_status |-> (rsp_r.data[15] == 1'b0) && (rsp_r.data[12:6] == 7'h00))
        else $error("unused status bits not zero");
    chk_range_upper: assert property (
        ans_range |-> rsp_r.data[15:2] == 14'h0000)
        else $error("range word upper bits not zero");
    chk_range_follows: assert property (
        ans_range && !(ans_absent && !$past(six_channel))
        |-> rsp_r.data[1:0] == $past(ch_range[sel.ch]))
        else $error("range word differs from channel range");
    chk_count_value: assert property (
        ans_count && !(ans_absent && !$past(six_channel))
        |-> rsp_r.data == $past(ch_count[sel.ch]))
        else $error("count word differs from channel count");
    chk_small_zero: assert property (
        ans_absent && !$past(six_channel) |-> rsp_r.data == 16'h0000)
        else $error("absent channel word not zero");
    chk_bad_function: assert property (
        rsp_valid_r && req_r.func != in_bank_pkg::FUNC_READ_INPUT
            && req_r.func != in_bank_pkg::FUNC_READ_HOLDING
        |-> rsp_r.exception && rsp_r.code == in_bank_pkg::EXC_ILLEGAL_FUNC)
        else $error("unsupported function not refused with exception 01");
    chk_answer_timing: assert property (
        req_valid && req_ready_r |=> !rsp_valid_r ##1 rsp_valid_r ##1 !rsp_valid_r)
        else $error("answer not a single pulse two cycles after request");
    chk_mirror_hit: assert property (
        rsp_valid_r && req_r.func == in_bank_pkg::FUNC_READ_HOLDING
            && req_r.addr >= 16'ha7f9 && req_r.addr <= 16'ha805
            // offset 0x0008 is a gap in the map, refused even through the mirror
            && req_r.addr != 16'ha801
        |-> !rsp_r.exception && rsp_r.code == in_bank_pkg::FUNC_READ_HOLDING)
        else $error("mirrored input register refused");

    cov_input_read: cover property (ans_ok && req_r.func == in_bank_pkg::FUNC_READ_INPUT);
    cov_mirror_read: cover property (ans_ok && req_r.func == in_bank_pkg::FUNC_READ_HOLDING);
    cov_bad_func: cover property (rsp_valid_r && rsp_r.code == in_bank_pkg::EXC_ILLEGAL_FUNC);
    cov_small_zero: cover property (ans_absent && !six_channel);
endmodule

// file: bench/read_client.sv
// read client model issuing one register read at a time
module read_client (
    // clock
    input wire logic ref_clk,
    // request side
    output logic req_valid,
    output in_bank_pkg::read_req_s req,
    input wire logic req_ready,
    // answer side
    input wire logic rsp_valid,
    input wire in_bank_pkg::read_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    in_bank_pkg::read_rsp_s got;
    int lat;
    logic pulse_after;
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // held until taken; released lines show the inverse, not a stale value
    task automatic read(input logic [7:0] f, input logic [15:0] a);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req <= {f, a};
        @(posedge ref_clk);
        while (req_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        req_valid <= 1'b0;
        req <= ~{f, a};
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 50) begin
            lat++;
            @(posedge ref_clk);
        end
        got = rsp;
        @(posedge ref_clk);
        pulse_after = rsp_valid;
    endtask
endmodule

// file: bench/test_output_module_input_registers.sv
// self-checking bench for the input register bank
module test_output_module_input_registers;
    timeunit 1ns;
    timeprecision 1ps;
    // generous: about four cycles per read
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid;
    logic req_ready;
    logic rsp_valid;
    in_bank_pkg::read_req_s req;
    in_bank_pkg::read_rsp_s rsp;
    logic wink_active = 1'b0;
    logic default_mode = 1'b0;
    logic six_channel = 1'b0;
    logic [5:0] wd_timeout = '0;
    logic [5:0][1:0] ch_range = '0;
    logic [5:0][15:0] ch_count = '0;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h7d560dc8;

    always #2 ref_clk = ~ref_clk;

    input_reg_bank dut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .wink_active(wink_active),
        .default_mode(default_mode), .wd_timeout(wd_timeout), .six_channel(six_channel),
        .ch_range(ch_range), .ch_count(ch_count));
    read_client cl (.ref_clk(ref_clk), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic in_bank_pkg::read_rsp_s expect_rsp(input logic [7:0] f,
        input logic [15:0] a);
        in_bank_pkg::read_rsp_s e;
        logic [15:0] off;
        int ch;
        e = '0;
        off = a;
        if (f != 8'h03 && f != 8'h04) begin
            e.exception = 1'b1;
            e.code = 8'h01;
            return e;
        end
        // mirror window covers offsets 0 to 0x000c only
        if (f == 8'h03) begin
            if (a < 16'ha7f9 || a > 16'ha805) begin
                e.exception = 1'b1;
                e.code = 8'h02;
                return e;
            end
            off = a - 16'ha7f9;
        end
        e.code = f;
        if (off == 16'h0000) begin
            e.data = {1'b0, wink_active, default_mode, 7'h00, wd_timeout};
        end else if (off <= 16'h0006) begin
            ch = int'(off) - 1;
            e.data = (ch >= 4 && !six_channel) ? 16'h0000 : {14'h0000, ch_range[ch]};
        end else if (off == 16'h0007 || off == 16'h8000
            || (off >= 16'h0009 && off <= 16'h000c)) begin
            ch = (off == 16'h0007) ? 0 : (off == 16'h8000) ? 1 : int'(off) - 7;
            e.data = (ch >= 4 && !six_channel) ? 16'h0000 : ch_count[ch];
        end else begin
            e.exception = 1'b1;
            e.code = 8'h02;
        end
        return e;
    endfunction

    task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_read(input logic [7:0] f, input logic [15:0] a);
        in_bank_pkg::read_rsp_s e;
        e = expect_rsp(f, a);
        cl.read(f, a);
        check("answer", cl.got, e);
        check("latency", 25'(cl.lat), 25'h0000002);
        check("pulse", 25'(cl.pulse_after), 25'h0000000);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            give_verdict;
        end
    end

    initial begin
        logic [31:0] v;
        repeat (20) @(posedge ref_clk);
        check("ready_in_reset", 25'(req_ready), 25'h0000000);
        check("valid_in_reset", 25'(rsp_valid), 25'h0000000);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int it = 0; it < 40; it++) begin
            // first two passes pin every state input to all ones, then all zeros
            for (int ch = 0; ch < 6; ch++) begin
                seed = lfsr(seed);
                v = (it == 0) ? '1 : (it == 1) ? '0 : seed;
                ch_count[ch] <= v[15:0];
                ch_range[ch] <= v[17:16];
                wd_timeout[ch] <= v[18];
            end
            wink_active <= v[19];
            default_mode <= v[20];
            six_channel <= v[21];
            @(posedge ref_clk);
            for (int k = 0; k < 13; k++) begin
                do_read(8'h04, (k == 8) ? 16'h8000 : 16'(k));
                do_read(8'h03, 16'ha7f9 + 16'(k));
            end
            if (it == 0) begin
                do_read(8'h04, 16'h0008);
                do_read(8'h04, 16'h000d);
                do_read(8'h03, 16'ha7f8);
                do_read(8'h03, 16'ha806);
                do_read(8'h05, 16'h0000);
                do_read(8'h11, 16'h0000);
            end
            seed = lfsr(seed);
            do_read(seed[31:24], seed[15:0]);
            $display("test %0d done", it);
        end
        give_verdict;
    end
endmodule
